// File: hw/uart_lms_pkg.sv
package uart_lms_pkg;

    localparam int          ADDR_W   = 9;
    localparam int          DATA_W   = 32;
    localparam int          REG_W    = 8;
    localparam int          CNT_W    = 8;
    localparam int          SCLK_W   = 4;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_MODEM_CONTROL    = 8'h04;
    localparam logic [7:0]  IDX_LINE_STATUS      = 8'h05;
    localparam logic [7:0]  IDX_MODEM_STATUS     = 8'h06;
    localparam logic [7:0]  IDX_SPECIAL_FUNCTION = 8'h07;
    localparam logic [7:0]  IDX_RX_COUNTER       = 8'h15;
    localparam logic [7:0]  IDX_TX_COUNTER       = 8'h16;

    // Line status fields
    localparam int          LS_RX_AVAIL    = 0;
    localparam int          LS_OVERRUN     = 1;
    localparam int          LS_PARITY      = 2;
    localparam int          LS_FRAMING     = 3;
    localparam int          LS_BREAK       = 4;
    localparam int          LS_THR_EMPTY   = 5;
    localparam int          LS_TSR_EMPTY   = 6;
    localparam int          LS_FIFO_ERROR  = 7;

    // Modem status fields
    localparam int          MS_DELTA_CTS   = 0;
    localparam int          MS_DELTA_DSR   = 1;
    localparam int          MS_RI_RISE     = 2;
    localparam int          MS_DELTA_DCD   = 3;
    localparam int          MS_CTS         = 4;
    localparam int          MS_DSR         = 5;
    localparam int          MS_RI          = 6;
    localparam int          MS_DCD         = 7;

    // Special function fields
    localparam int          SF_FORCE_TX    = 0;
    localparam int          SF_AUTO_DSR    = 1;
    localparam int          SF_ENHANCED    = 5;
    localparam int          SF_RX_CNT_SEL  = 6;
    localparam int          SF_TX_CNT_SEL  = 7;
    localparam logic [7:0]  SF_WRITE_MASK  = 8'he3;

    // Modem control fields
    localparam int          MC_DTR_LOW     = 0;
    localparam int          MC_AUX_ONE     = 2;
    localparam int          MC_AUX_TWO     = 3;
    localparam int          MC_LOOPBACK    = 4;
    localparam logic [7:0]  MC_WRITE_MASK  = 8'h1d;

    localparam logic [7:0]  SCLK_WRITE_MASK = 8'h0f;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [7:0]  RX_STOP_DEFAULT = 8'h38;

    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction

endpackage

// File: hw/uart_line_modem_status.sv
// Decided for this implementation: register access over AXI4-Lite.
module uart_line_modem_status
    import uart_lms_pkg::*;
#(
    parameter logic [7:0] RX_STOP_LEVEL = RX_STOP_DEFAULT
)
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite write
    input  wire logic [uart_lms_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [uart_lms_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // AXI4-Lite read
    input  wire logic [uart_lms_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [uart_lms_pkg::DATA_W-1:0]    s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Receiver and transmitter status
    input  wire logic                          rx_fifo_not_empty,
    input  wire logic                          rx_overrun,
    input  wire logic                          rx_parity_error,
    input  wire logic                          rx_framing_error,
    input  wire logic                          rx_break,
    input  wire logic                          tx_holding_empty,
    input  wire logic                          tx_shift_empty,
    input  wire logic                          rx_fifo_has_error,
    input  wire logic [uart_lms_pkg::CNT_W-1:0] rx_fifo_fill_count,
    input  wire logic [uart_lms_pkg::CNT_W-1:0] tx_fifo_fill_count,
    input  wire logic [uart_lms_pkg::CNT_W-1:0] line_status_error_count,
    // Modem handshake inputs
    input  wire logic                          cts,
    input  wire logic                          dsr,
    input  wire logic                          ri,
    input  wire logic                          dcd,
    // Controls to the datapath and pins
    output logic                               dtr_pin,
    output logic                               tx_permit,
    output logic                               tx_force,
    output logic                               enhanced_mode,
    output logic                               loopback_mode,
    output logic [uart_lms_pkg::SCLK_W-1:0]    sample_clock_setting
);
    import uart_lms_pkg::*;

    logic [7:0]        line_status_r;
    logic [7:0]        special_function_r;
    logic [7:0]        modem_control_r;
    logic [7:0]        sample_clock_r;
    logic [3:0]        delta_r;
    logic [3:0]        prev_r;
    logic              primed_r;
    logic              awready_r;
    logic              wready_r;
    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [7:0]        w_data_r;
    logic              w_lane_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [7:0]        rdata_r;
    logic [1:0]        rresp_r;
    logic              dtr_pin_r;
    logic              tx_permit_r;

    // Effective modem levels, loopback substitutes the aux outputs
    wire        loopback = modem_control_r[MC_LOOPBACK];
    wire        ri_eff   = loopback ? modem_control_r[MC_AUX_ONE] : ri;
    wire        dcd_eff  = loopback ? modem_control_r[MC_AUX_TWO] : dcd;
    wire [3:0]  now_lvl  = {dcd_eff, ri_eff, dsr, cts};

    // change detect on CTS, DSR, DCD, rising edge only on RI
    wire [3:0]  change   = primed_r ? (now_lvl ^ prev_r) : 4'h0;
    wire [3:0]  events   = {change[3], change[2] & ri_eff, change[1], change[0]};

    // live levels in the upper half
    wire [7:0]  modem_status = {dcd_eff, ri_eff, dsr, cts, delta_r};

    wire [7:0]  line_status_nxt = {rx_fifo_has_error, tx_shift_empty, tx_holding_empty,
                                   rx_break, rx_framing_error, rx_parity_error,
                                   rx_overrun, rx_fifo_not_empty};

    // Write channel decode
    wire        aw_hs    = s_axi_awvalid & awready_r;
    wire        w_hs     = s_axi_wvalid & wready_r;
    wire        do_write = aw_held_r & w_held_r & ~bvalid_r;
    wire        wr_sf    = aw_addr_r == byte_addr(IDX_SPECIAL_FUNCTION);
    wire        wr_mc    = aw_addr_r == byte_addr(IDX_MODEM_CONTROL);
    wire        wr_tx    = aw_addr_r == byte_addr(IDX_TX_COUNTER);
    wire        wr_ro    = (aw_addr_r == byte_addr(IDX_LINE_STATUS))
                         | (aw_addr_r == byte_addr(IDX_MODEM_STATUS))
                         | (aw_addr_r == byte_addr(IDX_RX_COUNTER));
    wire        wr_hit   = wr_sf | wr_mc | wr_tx | wr_ro;
    wire        wr_en    = do_write & w_lane_r;
    // sample clock is writable only while selected
    wire        wr_sclk  = wr_en & wr_tx & ~special_function_r[SF_TX_CNT_SEL];

    wire [7:0]  special_function_nxt = w_data_r & SF_WRITE_MASK;
    wire [7:0]  modem_control_nxt    = w_data_r & MC_WRITE_MASK;
    wire [7:0]  sample_clock_nxt     = w_data_r & SCLK_WRITE_MASK;

    // Read channel decode
    wire        ar_hs    = s_axi_arvalid & arready_r;
    wire        r_ls     = s_axi_araddr == byte_addr(IDX_LINE_STATUS);
    wire        r_ms     = s_axi_araddr == byte_addr(IDX_MODEM_STATUS);
    wire        r_sf     = s_axi_araddr == byte_addr(IDX_SPECIAL_FUNCTION);
    wire        r_mc     = s_axi_araddr == byte_addr(IDX_MODEM_CONTROL);
    wire        r_rx     = s_axi_araddr == byte_addr(IDX_RX_COUNTER);
    wire        r_tx     = s_axi_araddr == byte_addr(IDX_TX_COUNTER);
    wire        r_hit    = r_ls | r_ms | r_sf | r_mc | r_rx | r_tx;
    wire        ms_read  = ar_hs & r_ms;
    // counter select at the receive counter slot
    wire [7:0]  rx_slot  = special_function_r[SF_RX_CNT_SEL] ? line_status_error_count
                                                              : rx_fifo_fill_count;
    // counter select at the transmit counter slot
    wire [7:0]  tx_slot  = special_function_r[SF_TX_CNT_SEL] ? tx_fifo_fill_count
                                                              : sample_clock_r;
    wire [7:0]  rd_mux   = r_ls ? line_status_r
                         : r_ms ? modem_status
                         : r_sf ? special_function_r
                         : r_mc ? modem_control_r
                         : r_rx ? rx_slot
                         : r_tx ? tx_slot
                         : 8'h00;

    wire [3:0]  delta_nxt = (ms_read ? 4'h0 : delta_r) | events;

    // DTR held back when auto flow is on and the FIFO is full enough
    wire        dtr_auto  = rx_fifo_fill_count >= RX_STOP_LEVEL;
    wire        dtr_nxt   = special_function_r[SF_AUTO_DSR] ? dtr_auto
                                                            : ~modem_control_r[MC_DTR_LOW];
    wire        permit_nxt = special_function_r[SF_FORCE_TX]
                           | ~special_function_r[SF_AUTO_DSR]
                           | dsr;

    // Status sampling and modem deltas
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            line_status_r <= REG_RESET;
            delta_r       <= 4'h0;
            prev_r        <= 4'h0;
            primed_r      <= 1'b0;
        end
        else
        begin
            line_status_r <= line_status_nxt;
            delta_r       <= delta_nxt;
            prev_r        <= now_lvl;
            primed_r      <= 1'b1;
        end
    end

    // Software written registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            special_function_r <= REG_RESET;
            modem_control_r    <= REG_RESET;
            sample_clock_r     <= REG_RESET;
        end
        else
        begin
            if (wr_en & wr_sf)
                special_function_r <= special_function_nxt;
            if (wr_en & wr_mc)
                modem_control_r <= modem_control_nxt;
            if (wr_sclk)
                sample_clock_r <= sample_clock_nxt;
        end
    end

    // Write address and data capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            aw_addr_r <= '0;
            w_data_r  <= 8'h00;
            w_lane_r  <= 1'b0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_held_r <= 1'b1;
                awready_r <= 1'b0;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_r <= 1'b0;
            if (w_hs)
            begin
                w_held_r <= 1'b1;
                wready_r <= 1'b0;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end
            else if (do_write)
                w_held_r <= 1'b0;
            if (bvalid_r & s_axi_bready)
            begin
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Read path, one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 8'h00;
            rresp_r   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= r_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r & s_axi_rready)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // Pin and datapath controls
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dtr_pin_r   <= 1'b1;
            tx_permit_r <= 1'b1;
        end
        else
        begin
            dtr_pin_r   <= dtr_nxt;
            tx_permit_r <= permit_nxt;
        end
    end

    assign s_axi_awready        = awready_r;
    assign s_axi_wready         = wready_r;
    assign s_axi_bvalid         = bvalid_r;
    assign s_axi_bresp          = bresp_r;
    assign s_axi_arready        = arready_r;
    assign s_axi_rvalid         = rvalid_r;
    assign s_axi_rdata          = {24'h000000, rdata_r};
    assign s_axi_rresp          = rresp_r;
    assign dtr_pin              = dtr_pin_r;
    assign tx_permit            = tx_permit_r;
    assign tx_force             = special_function_r[SF_FORCE_TX];
    assign enhanced_mode        = special_function_r[SF_ENHANCED];
    assign loopback_mode        = modem_control_r[MC_LOOPBACK];
    assign sample_clock_setting = sample_clock_r[SCLK_W-1:0];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_ls_rx_avail: assert property ($past(aresetn) |->
        line_status_r[LS_RX_AVAIL] == $past(rx_fifo_not_empty))
        else $error("rx available bit wrong");
    a_ls_overrun: assert property ($past(aresetn) |->
        line_status_r[LS_OVERRUN] == $past(rx_overrun))
        else $error("overrun bit wrong");
    a_ls_errors: assert property ($past(aresetn) |->
        line_status_r[LS_FRAMING:LS_PARITY] == $past({rx_framing_error, rx_parity_error}))
        else $error("parity or framing bit wrong");
    a_ls_tx_done: assert property ($past(aresetn) |->
        line_status_r[LS_TSR_EMPTY] == $past(tx_shift_empty))
        else $error("shift empty bit wrong");
    a_cts_delta_set: assert property (primed_r && $changed(cts) |=>
        delta_r[MS_DELTA_CTS])
        else $error("cts change not latched");
    a_delta_read_clear: assert property (ms_read && events == 4'h0 |=>
        delta_r == 4'h0)
        else $error("read did not clear deltas");
    a_ri_rise_set: assert property (!loopback && !$past(loopback)
        && primed_r && $rose(ri) |=> delta_r[MS_RI_RISE])
        else $error("ri rising edge not latched");
    a_ms_live_levels: assert property (ar_hs && r_ms |=>
        rdata_r[MS_DSR:MS_CTS] == $past({dsr, cts}))
        else $error("cts or dsr level wrong");
    a_ri_fall_quiet: assert property (!loopback && primed_r && $fell(ri)
        && !delta_r[MS_RI_RISE] |=> !delta_r[MS_RI_RISE])
        else $error("ri falling edge latched");
    a_sf_reserved_zero: assert property (
        (special_function_r & ~SF_WRITE_MASK) == 8'h00)
        else $error("reserved special bits set");
    a_rx_slot_read: assert property (ar_hs && r_rx |=>
        rdata_r == $past(special_function_r[SF_RX_CNT_SEL] ? line_status_error_count
                                                           : rx_fifo_fill_count))
        else $error("receive counter slot wrong");
    a_loop_ri_route: assert property (ar_hs && r_ms && loopback |=>
        rdata_r[MS_RI] == $past(modem_control_r[MC_AUX_ONE]))
        else $error("loopback ri not routed");
    a_force_permit: assert property (special_function_r[SF_FORCE_TX] |=>
        tx_permit_r)
        else $error("forced transmit gated");

    c_ms_read_clear: cover property (ms_read ##1 rvalid_r && rdata_r[3:0] != 4'h0);
    c_write_sf:      cover property (do_write && wr_sf && w_lane_r);
    c_set_on_clear:  cover property (ms_read && events != 4'h0);
    c_loopback_ri:   cover property (loopback && events[MS_RI_RISE]);

endmodule

// File: bench/remote_modem.sv
module remote_modem
(
    // Clock
    input  wire logic aclk,
    // Handshake lines towards the device
    output logic      cts,
    output logic      dsr,
    output logic      ri,
    output logic      dcd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {dcd, ri, dsr, cts} = 4'h0;
    end

    // Changes the lines after a chosen delay, so answers can be prompt or slow
    task automatic drive(input logic [3:0] v, input int delay);
        repeat (delay) @(posedge aclk);
        {dcd, ri, dsr, cts} <= v;
        repeat (2) @(posedge aclk);
    endtask
endmodule

// File: bench/uart_line_modem_status_tb.sv
module uart_line_modem_status_tb;
    import uart_lms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk;
    logic        aresetn;
    logic [8:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [8:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic [7:0]  ls_in;
    logic [7:0]  rx_fill;
    logic [7:0]  tx_fill;
    logic [7:0]  err_cnt;
    logic        cts;
    logic        dsr;
    logic        ri;
    logic        dcd;
    logic        dtr_pin;
    logic        tx_permit;
    logic        tx_force;
    logic        enhanced_mode;
    logic        loopback_mode;
    logic [3:0]  sclk;
    logic [31:0] d;
    logic [1:0]  r;
    int          errors;
    int          checks;

    uart_line_modem_status dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_fifo_not_empty(ls_in[0]), .rx_overrun(ls_in[1]),
        .rx_parity_error(ls_in[2]), .rx_framing_error(ls_in[3]), .rx_break(ls_in[4]),
        .tx_holding_empty(ls_in[5]), .tx_shift_empty(ls_in[6]),
        .rx_fifo_has_error(ls_in[7]), .rx_fifo_fill_count(rx_fill),
        .tx_fifo_fill_count(tx_fill), .line_status_error_count(err_cnt),
        .cts(cts), .dsr(dsr), .ri(ri), .dcd(dcd), .dtr_pin(dtr_pin),
        .tx_permit(tx_permit), .tx_force(tx_force), .enhanced_mode(enhanced_mode),
        .loopback_mode(loopback_mode), .sample_clock_setting(sclk)
    );

    remote_modem modem_u (.aclk(aclk), .cts(cts), .dsr(dsr), .ri(ri), .dcd(dcd));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Wide enough for a read word packed beside a response or a pin
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] v, output logic [1:0] resp);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask

    task automatic rd(input logic [8:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
    endtask

    task automatic t_line_status;
        for (int i = 0; i < 9; i++)
        begin
            ls_in <= (i < 8) ? 8'h01 << i : 8'h00;
            repeat (2) @(posedge aclk);
            rd(9'h014, d, r);
            check(d, (i < 8) ? 32'h1 << i : 32'h0);
        end
    endtask

    task automatic t_special;
        wr(9'h01c, 8'hff, r);
        rd(9'h01c, d, r);
        check(d, 32'he3);
        check({enhanced_mode, tx_force}, 2'b11);
        wr(9'h01c, 8'h00, r);
        check({enhanced_mode, tx_force}, 2'b00);
    endtask

    task automatic t_counters;
        rx_fill <= 8'h21;
        tx_fill <= 8'h42;
        err_cnt <= 8'h63;
        wr(9'h058, 8'h0b, r);
        rd(9'h054, d, r);
        check(d, 32'h21);
        rd(9'h058, d, r);
        check({d, 28'h0, sclk}, {32'h0b, 32'hb});
        wr(9'h01c, 8'hc0, r);
        rd(9'h054, d, r);
        check(d, 32'h63);
        wr(9'h058, 8'h05, r);
        rd(9'h058, d, r);
        check(d, 32'h42);
        wr(9'h01c, 8'h00, r);
        rd(9'h058, d, r);
        check(d, 32'h0b);
        rd(9'h1fc, d, r);
        check({d, 30'h0, r}, {32'h0, 30'h0, RESP_SLVERR});
        wr(9'h1fc, 8'h11, r);
        check(r, RESP_SLVERR);
    endtask

    task automatic t_flow;
        check({dtr_pin, tx_permit}, 2'b11);
        wr(9'h01c, 8'h02, r);
        rx_fill <= 8'h37;
        repeat (2) @(posedge aclk);
        check({dtr_pin, tx_permit}, 2'b00);
        rx_fill <= 8'h38;
        modem_u.drive(4'h2, 3);
        check({dtr_pin, tx_permit}, 2'b11);
        wr(9'h01c, 8'h03, r);
        modem_u.drive(4'h0, 0);
        check(tx_permit, 1'b1);
        wr(9'h01c, 8'h00, r);
    endtask

    task automatic t_modem;
        rd(9'h018, d, r);
        for (int i = 0; i < 4; i++)
        begin
            modem_u.drive(4'h1 << i, i);
            rd(9'h018, d, r);
            check(d, (32'h11 << i));
            rd(9'h018, d, r);
            check(d, (32'h10 << i));
            modem_u.drive(4'h0, 1);
            rd(9'h018, d, r);
            check(d, (i == 2) ? 32'h0 : 32'h1 << i);
            rd(9'h018, d, r);
        end
    endtask

    task automatic t_loopback;
        wr(9'h010, 8'h1c, r);
        repeat (2) @(posedge aclk);
        rd(9'h018, d, r);
        check({d, 31'h0, loopback_mode}, {32'hcc, 32'h1});
        wr(9'h010, 8'h00, r);
        repeat (2) @(posedge aclk);
        rd(9'h018, d, r);
        check(d, 32'h08);
    endtask

    initial
    begin
        errors = 0;
        checks = 0;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, ls_in, rx_fill, tx_fill, err_cnt} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(9'h01c, d, r);
        check({d, 30'h0, r}, {32'h0, 30'h0, RESP_OKAY});
        t_line_status();
        t_special();
        t_counters();
        t_flow();
        t_modem();
        t_loopback();
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_sim();
    end
endmodule
